/* hw/tcdr_defs.vh */
/*
  Constants for the timer control and data register block: register
  addresses on the special function register port, bit positions of the
  control registers, reset values and mode encodings.
  Assumes it is included by its bare name from the block's design file.
*/
`ifndef TCDR_DEFS_VH
`define TCDR_DEFS_VH

// Register addresses.
`define TCDR_ADDR_CTRL01 8'h88
`define TCDR_ADDR_MODE01 8'h89
`define TCDR_ADDR_T0_LOW 8'h8A
`define TCDR_ADDR_T1_LOW 8'h8B
`define TCDR_ADDR_T0_HIGH 8'h8C
`define TCDR_ADDR_T1_HIGH 8'h8D
`define TCDR_ADDR_CTRL2 8'hC8
`define TCDR_ADDR_RLD2_LOW 8'hCA
`define TCDR_ADDR_RLD2_HIGH 8'hCB
`define TCDR_ADDR_TMR2_LOW 8'hCC
`define TCDR_ADDR_TMR2_HIGH 8'hCD

// Bit positions in timer01_and_ext_irq_control.
`define TCDR_B_OVF1 7
`define TCDR_B_RUN1 6
`define TCDR_B_OVF0 5
`define TCDR_B_RUN0 4
`define TCDR_B_EIRQ1 3
`define TCDR_B_EDGE1 2
`define TCDR_B_EIRQ0 1
`define TCDR_B_EDGE0 0

// Bit positions in timer01_mode.
`define TCDR_B_PGATE1 7
`define TCDR_B_CT1 6
`define TCDR_B_M1_HI 5
`define TCDR_B_M1_LO 4
`define TCDR_B_PGATE0 3
`define TCDR_B_CT0 2
`define TCDR_B_M0_HI 1
`define TCDR_B_M0_LO 0

// Bit positions in timer2_control.
`define TCDR_B_OVF2 7
`define TCDR_B_XFLAG2 6
`define TCDR_B_RXSEL 5
`define TCDR_B_TXSEL 4
`define TCDR_B_XEN2 3
`define TCDR_B_RUN2 2
`define TCDR_B_CNTSEL2 1
`define TCDR_B_CAPSEL2 0

// Reset values.
`define TCDR_RST_BYTE 8'h00
`define TCDR_RST_BIT 1'h0
`define TCDR_RST_PIN 1'h1

// Timer 0/1 mode encodings.
`define TCDR_MODE_13BIT 2'h0
`define TCDR_MODE_16BIT 2'h1
`define TCDR_MODE_RELOAD8 2'h2
`define TCDR_MODE_SPLIT 2'h3

`endif

/* hw/tcdr_top.v */
/*
  Timer 0, Timer 1 and Timer 2 control, status and data registers, plus
  the two external interrupt flags, behind a simple register port.
  Assumes every pin input is synchronous to clock, that the core pulses
  one acknowledge line per source when it vectors, and that the register
  master never asserts read and write strobes together.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tcdr_defs.vh"

// Behaviour
// [R1] Timer 1 overflow sets its flag; vectoring acknowledge clears it.
// [R2] Timer 1 counts only while its run bit is one.
// [R3] Timer 0 overflow sets its flag; vectoring acknowledge clears it.
// [R4] Timer 0 counts only while its run bit is one.
// [R5] Interrupt 1 flag: falling edge or low level; edge flag cleared on vectoring.
// [R6] Interrupt 0 flag behaves the same way on its own pin.
// [R7] Trigger-type bit one selects edge, zero selects level; both reset zero.
// [R8] Low four control bits serve only the external interrupt pins.
// [R9] Timer 2 overflow sets its flag unless a baud select bit is one.
// [R10] Trigger-pin capture or reload with enable sets the external flag.
// [R11] Receive baud tick comes from Timer 2 when selected, else Timer 1.
// [R12] Transmit baud tick comes from Timer 2 when selected, else Timer 1.
// [R13] Trigger-pin falling edge acts only with enable set and no baud use.
// [R14] Timer 2 counts only while its run bit is one.
// [R15] Function select one counts count-pin edges, zero counts core clocks.
// [R16] Capture select picks capture or reload; baud use forces reload.
// [R17] Each timer has readable, writable high and low bytes resetting to zero.
// [R18] Timer 0 counts while run is one and gating is off or pin high.
// [R19] 8-bit reload mode reloads the low byte from the high byte.
// [R20] Timer 2 reload mode loads the count from the reload pair on rollover.
// [R21] Timer 2 capture copies the count into the reload pair on an edge.
// [R22] The core pulses a per-source acknowledge when it vectors.
module tcdr_top (
  input wire clock,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire ext_irq0_pin,
  input wire ext_irq1_pin,
  input wire timer0_count_pin,
  input wire timer1_count_pin,
  input wire timer2_count_pin,
  input wire timer2_trigger_pin,
  input wire ack_timer0,
  input wire ack_timer1,
  input wire ack_ext_irq0,
  input wire ack_ext_irq1,
  output reg timer0_overflow_flag,
  output reg timer1_overflow_flag,
  output reg ext_irq0_flag,
  output reg ext_irq1_flag,
  output reg timer2_overflow_flag,
  output reg timer2_ext_flag,
  output reg rx_baud_tick,
  output reg tx_baud_tick
);

  // Control bits.
  reg timer0_run_r;
  reg timer1_run_r;
  reg ext_irq0_edge_select_r;
  reg ext_irq1_edge_select_r;
  reg [7:0] timer01_mode_r;
  reg rx_baud_from_timer2_r;
  reg tx_baud_from_timer2_r;
  reg timer2_ext_trigger_enable_r;
  reg timer2_run_r;
  reg timer2_counter_select_r;
  reg timer2_capture_select_r;

  // Data bytes.
  reg [7:0] timer0_count_low_r;
  reg [7:0] timer0_count_high_r;
  reg [7:0] timer1_count_low_r;
  reg [7:0] timer1_count_high_r;
  reg [7:0] timer2_count_low_r;
  reg [7:0] timer2_count_high_r;
  reg [7:0] timer2_reload_low_r;
  reg [7:0] timer2_reload_high_r;

  // Previous pin levels for falling-edge detection; idle high.
  reg ext0_prev_r;
  reg ext1_prev_r;
  reg cnt0_prev_r;
  reg cnt1_prev_r;
  reg cnt2_prev_r;
  reg trig2_prev_r;

  // Next values.
  reg [7:0] t0_low_nxt;
  reg [7:0] t0_high_nxt;
  reg [7:0] t1_low_nxt;
  reg [7:0] t1_high_nxt;
  reg [7:0] tmr2_low_nxt;
  reg [7:0] tmr2_high_nxt;
  reg [7:0] rld2_low_nxt;
  reg [7:0] rld2_high_nxt;
  // Hardware set requests for the Timer 0/1 flags, one cycle wide.
  reg ovf0_set;
  reg ovf1_set;
  reg t1_ovf_pulse;
  reg [16:0] step0;
  reg [16:0] step1;
  reg [15:0] split_high_sum;

  // One count step for modes 13-bit, 16-bit and 8-bit reload.
  // Result is {overflow, high byte, low byte}.
  function [16:0] tcdr_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [15:0] s16;
    reg [12:0] s13;
    begin
      s16 = {hi, lo} + 16'h0001;
      s13 = {hi, lo[4:0]} + 13'h0001;
      case (mode)
        `TCDR_MODE_13BIT: begin
          // Upper three low-byte bits are not part of the count.
          tcdr_step = {&{hi, lo[4:0]}, s13[12:5], lo[7:5], s13[4:0]};
        end
        `TCDR_MODE_16BIT: begin
          tcdr_step = {&{hi, lo}, s16};
        end
        default: begin
          tcdr_step = {&lo, hi, (&lo) ? hi : s16[7:0]}; // [R19]
        end
      endcase
    end
  endfunction

  wire [1:0] mode0 = timer01_mode_r[`TCDR_B_M0_HI:`TCDR_B_M0_LO];
  wire [1:0] mode1 = timer01_mode_r[`TCDR_B_M1_HI:`TCDR_B_M1_LO];
  wire split0 = (mode0 == `TCDR_MODE_SPLIT);

  // Count sources: a core clock, or a falling edge on the count pin.
  wire src0 = timer01_mode_r[`TCDR_B_CT0] ? (cnt0_prev_r & ~timer0_count_pin) : 1'b1;
  wire src1 = timer01_mode_r[`TCDR_B_CT1] ? (cnt1_prev_r & ~timer1_count_pin) : 1'b1;
  wire src2 = timer2_counter_select_r ? (cnt2_prev_r & ~timer2_count_pin) : 1'b1; // [R15]

  // Gating lets a high interrupt pin time an external pulse width.
  wire timer0_pin_gating_ok = ~timer01_mode_r[`TCDR_B_PGATE0] | ext_irq0_pin;
  wire gate1_ok = ~timer01_mode_r[`TCDR_B_PGATE1] | ext_irq1_pin;
  wire inc0 = timer0_run_r & timer0_pin_gating_ok & src0; // [R4] [R18]
  // Timer 1 holds its count in its own split mode.
  wire inc1 = timer1_run_r & gate1_ok & src1 & (mode1 != `TCDR_MODE_SPLIT); // [R2]
  // In split mode the Timer 0 high byte borrows the Timer 1 run bit.
  wire inc0_high = split0 & timer1_run_r;

  wire baud2 = rx_baud_from_timer2_r | tx_baud_from_timer2_r;
  wire inc2 = timer2_run_r & src2; // [R14]
  wire [15:0] sum2 = {timer2_count_high_r, timer2_count_low_r} + 16'h0001;
  wire ovf2 = inc2 & (&{timer2_count_high_r, timer2_count_low_r});
  // Trigger pin is ignored without enable or while Timer 2 drives the baud clock.
  wire trig2 = trig2_prev_r & ~timer2_trigger_pin & timer2_ext_trigger_enable_r & ~baud2; // [R13]
  wire reload_mode2 = ~timer2_capture_select_r | baud2; // [R16]

  wire wr_ctrl01 = reg_write & (reg_addr == `TCDR_ADDR_CTRL01);
  wire wr_ctrl2 = reg_write & (reg_addr == `TCDR_ADDR_CTRL2);

  // Timer 0 and Timer 1 count logic.
  always @* begin
    step0 = tcdr_step(mode0, timer0_count_high_r, timer0_count_low_r);
    step1 = tcdr_step(mode1, timer1_count_high_r, timer1_count_low_r);
    split_high_sum = {8'h00, timer0_count_high_r} + 16'h0001;
    t0_low_nxt = timer0_count_low_r;
    t0_high_nxt = timer0_count_high_r;
    t1_low_nxt = timer1_count_low_r;
    t1_high_nxt = timer1_count_high_r;
    ovf0_set = 1'b0;
    ovf1_set = 1'b0;
    t1_ovf_pulse = 1'b0;
    if (split0) begin
      // Split mode: the low byte is a plain 8-bit counter that wraps to zero.
      if (inc0) begin
        t0_low_nxt = timer0_count_low_r + 8'h01;
        ovf0_set = &timer0_count_low_r; // [R3]
      end
      // The high byte only ever counts core clocks.
      if (inc0_high) begin
        t0_high_nxt = split_high_sum[7:0];
        ovf1_set = &timer0_count_high_r; // [R1]
      end
    end else if (inc0) begin
      t0_high_nxt = step0[15:8];
      t0_low_nxt = step0[7:0];
      ovf0_set = step0[16]; // [R3]
    end
    if (inc1) begin
      t1_high_nxt = step1[15:8];
      t1_low_nxt = step1[7:0];
      t1_ovf_pulse = step1[16];
      // While Timer 0 is split, Timer 1 only feeds the baud clock.
      ovf1_set = split0 ? ovf1_set : step1[16]; // [R1]
    end
    // A software write to a data byte wins over the count in that cycle.
    if (reg_write) begin
      case (reg_addr)
        `TCDR_ADDR_T0_LOW: t0_low_nxt = reg_wdata; // [R17]
        `TCDR_ADDR_T0_HIGH: t0_high_nxt = reg_wdata; // [R17]
        `TCDR_ADDR_T1_LOW: t1_low_nxt = reg_wdata; // [R17]
        `TCDR_ADDR_T1_HIGH: t1_high_nxt = reg_wdata; // [R17]
        default: begin
        end
      endcase
    end
  end

  // Timer 2 count, reload and capture logic.
  always @* begin
    tmr2_low_nxt = timer2_count_low_r;
    tmr2_high_nxt = timer2_count_high_r;
    rld2_low_nxt = timer2_reload_low_r;
    rld2_high_nxt = timer2_reload_high_r;
    // A reload beats the plain increment, so the count never passes through zero.
    // In capture mode an overflow simply wraps the count to zero.
    if ((ovf2 & reload_mode2) | (trig2 & ~timer2_capture_select_r)) begin
      tmr2_low_nxt = timer2_reload_low_r; // [R20]
      tmr2_high_nxt = timer2_reload_high_r; // [R20]
    end else if (inc2) begin
      tmr2_low_nxt = sum2[7:0];
      tmr2_high_nxt = sum2[15:8];
    end
    // The capture takes the count as it stood before this edge's increment.
    if (trig2 & timer2_capture_select_r) begin
      rld2_low_nxt = timer2_count_low_r; // [R21]
      rld2_high_nxt = timer2_count_high_r; // [R21]
    end
    if (reg_write) begin
      case (reg_addr)
        `TCDR_ADDR_TMR2_LOW: tmr2_low_nxt = reg_wdata; // [R17]
        `TCDR_ADDR_TMR2_HIGH: tmr2_high_nxt = reg_wdata; // [R17]
        // Software presets the reload pair; a capture in the same cycle loses.
        `TCDR_ADDR_RLD2_LOW: rld2_low_nxt = reg_wdata;
        `TCDR_ADDR_RLD2_HIGH: rld2_high_nxt = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Flags: every hardware set wins over a clear in the same cycle.
  wire ext0_fall = ext0_prev_r & ~ext_irq0_pin;
  wire ext1_fall = ext1_prev_r & ~ext_irq1_pin;
  // A software write replaces the held value; the hardware set is ORed in later.
  wire ovf0_keep = wr_ctrl01 ? reg_wdata[`TCDR_B_OVF0] : timer0_overflow_flag;
  wire ovf1_keep = wr_ctrl01 ? reg_wdata[`TCDR_B_OVF1] : timer1_overflow_flag;
  wire eirq0_keep = wr_ctrl01 ? reg_wdata[`TCDR_B_EIRQ0] : ext_irq0_flag;
  wire eirq1_keep = wr_ctrl01 ? reg_wdata[`TCDR_B_EIRQ1] : ext_irq1_flag;
  wire ovf2_keep = wr_ctrl2 ? reg_wdata[`TCDR_B_OVF2] : timer2_overflow_flag;
  wire xflag2_keep = wr_ctrl2 ? reg_wdata[`TCDR_B_XFLAG2] : timer2_ext_flag;
  // Level mode: the flag simply mirrors the low pin; edge mode latches.
  // Software cannot hold a level flag, since the pin owns it entirely.
  wire eirq0_nxt = ext_irq0_edge_select_r ? ((eirq0_keep & ~ack_ext_irq0) | ext0_fall)
                                          : ~ext_irq0_pin; // [R6] [R7] [R22]
  wire eirq1_nxt = ext_irq1_edge_select_r ? ((eirq1_keep & ~ack_ext_irq1) | ext1_fall)
                                          : ~ext_irq1_pin; // [R5] [R7] [R22]

  always @(posedge clock) begin
    if (reset) begin
      timer0_run_r <= `TCDR_RST_BIT;
      timer1_run_r <= `TCDR_RST_BIT;
      ext_irq0_edge_select_r <= `TCDR_RST_BIT; // [R7]
      ext_irq1_edge_select_r <= `TCDR_RST_BIT; // [R7]
      timer01_mode_r <= `TCDR_RST_BYTE;
      rx_baud_from_timer2_r <= `TCDR_RST_BIT;
      tx_baud_from_timer2_r <= `TCDR_RST_BIT;
      timer2_ext_trigger_enable_r <= `TCDR_RST_BIT;
      timer2_run_r <= `TCDR_RST_BIT;
      timer2_counter_select_r <= `TCDR_RST_BIT;
      timer2_capture_select_r <= `TCDR_RST_BIT;
      timer0_count_low_r <= `TCDR_RST_BYTE; // [R17]
      timer0_count_high_r <= `TCDR_RST_BYTE;
      timer1_count_low_r <= `TCDR_RST_BYTE;
      timer1_count_high_r <= `TCDR_RST_BYTE;
      timer2_count_low_r <= `TCDR_RST_BYTE;
      timer2_count_high_r <= `TCDR_RST_BYTE;
      timer2_reload_low_r <= `TCDR_RST_BYTE;
      timer2_reload_high_r <= `TCDR_RST_BYTE;
      ext0_prev_r <= `TCDR_RST_PIN;
      ext1_prev_r <= `TCDR_RST_PIN;
      cnt0_prev_r <= `TCDR_RST_PIN;
      cnt1_prev_r <= `TCDR_RST_PIN;
      cnt2_prev_r <= `TCDR_RST_PIN;
      trig2_prev_r <= `TCDR_RST_PIN;
      timer0_overflow_flag <= `TCDR_RST_BIT;
      timer1_overflow_flag <= `TCDR_RST_BIT;
      ext_irq0_flag <= `TCDR_RST_BIT;
      ext_irq1_flag <= `TCDR_RST_BIT;
      timer2_overflow_flag <= `TCDR_RST_BIT;
      timer2_ext_flag <= `TCDR_RST_BIT;
      rx_baud_tick <= `TCDR_RST_BIT;
      tx_baud_tick <= `TCDR_RST_BIT;
      reg_rdata <= `TCDR_RST_BYTE;
    end else begin
      if (wr_ctrl01) begin
        timer1_run_r <= reg_wdata[`TCDR_B_RUN1]; // [R2]
        timer0_run_r <= reg_wdata[`TCDR_B_RUN0]; // [R4]
        // These two bits steer only the external interrupt flags.
        ext_irq1_edge_select_r <= reg_wdata[`TCDR_B_EDGE1]; // [R8]
        ext_irq0_edge_select_r <= reg_wdata[`TCDR_B_EDGE0]; // [R8]
      end
      // A mode change takes effect on the next count; the count itself is kept.
      if (reg_write & (reg_addr == `TCDR_ADDR_MODE01)) begin
        timer01_mode_r <= reg_wdata;
      end
      // The flag bits of this register are handled with the flags below.
      if (wr_ctrl2) begin
        rx_baud_from_timer2_r <= reg_wdata[`TCDR_B_RXSEL];
        tx_baud_from_timer2_r <= reg_wdata[`TCDR_B_TXSEL];
        timer2_ext_trigger_enable_r <= reg_wdata[`TCDR_B_XEN2];
        timer2_run_r <= reg_wdata[`TCDR_B_RUN2]; // [R14]
        timer2_counter_select_r <= reg_wdata[`TCDR_B_CNTSEL2];
        timer2_capture_select_r <= reg_wdata[`TCDR_B_CAPSEL2];
      end
      timer0_count_low_r <= t0_low_nxt;
      timer0_count_high_r <= t0_high_nxt;
      timer1_count_low_r <= t1_low_nxt;
      timer1_count_high_r <= t1_high_nxt;
      timer2_count_low_r <= tmr2_low_nxt;
      timer2_count_high_r <= tmr2_high_nxt;
      timer2_reload_low_r <= rld2_low_nxt;
      timer2_reload_high_r <= rld2_high_nxt;
      ext0_prev_r <= ext_irq0_pin;
      ext1_prev_r <= ext_irq1_pin;
      cnt0_prev_r <= timer0_count_pin;
      cnt1_prev_r <= timer1_count_pin;
      cnt2_prev_r <= timer2_count_pin;
      trig2_prev_r <= timer2_trigger_pin;
      // An overflow in the cycle of an acknowledge keeps the flag set, so no
      // interrupt is lost when the core vectors just as the timer wraps again.
      timer0_overflow_flag <= (ovf0_keep & ~ack_timer0) | ovf0_set; // [R3] [R22]
      timer1_overflow_flag <= (ovf1_keep & ~ack_timer1) | ovf1_set; // [R1] [R22]
      ext_irq0_flag <= eirq0_nxt; // [R6]
      ext_irq1_flag <= eirq1_nxt; // [R5]
      // Software alone clears the Timer 2 flags.
      timer2_overflow_flag <= ovf2_keep | (ovf2 & ~baud2); // [R9]
      timer2_ext_flag <= xflag2_keep | trig2; // [R10]
      // Baud ticks are one-cycle pulses for the serial port's divider.
      rx_baud_tick <= rx_baud_from_timer2_r ? ovf2 : t1_ovf_pulse; // [R11]
      tx_baud_tick <= tx_baud_from_timer2_r ? ovf2 : t1_ovf_pulse; // [R12]
      reg_rdata <= `TCDR_RST_BYTE;
      if (reg_read) begin
        case (reg_addr)
          `TCDR_ADDR_CTRL01: reg_rdata <= {timer1_overflow_flag, timer1_run_r,
                                           timer0_overflow_flag, timer0_run_r,
                                           ext_irq1_flag, ext_irq1_edge_select_r,
                                           ext_irq0_flag, ext_irq0_edge_select_r};
          `TCDR_ADDR_MODE01: reg_rdata <= timer01_mode_r;
          `TCDR_ADDR_T0_LOW: reg_rdata <= timer0_count_low_r;
          `TCDR_ADDR_T1_LOW: reg_rdata <= timer1_count_low_r;
          `TCDR_ADDR_T0_HIGH: reg_rdata <= timer0_count_high_r;
          `TCDR_ADDR_T1_HIGH: reg_rdata <= timer1_count_high_r;
          `TCDR_ADDR_CTRL2: reg_rdata <= {timer2_overflow_flag, timer2_ext_flag,
                                          rx_baud_from_timer2_r, tx_baud_from_timer2_r,
                                          timer2_ext_trigger_enable_r, timer2_run_r,
                                          timer2_counter_select_r, timer2_capture_select_r};
          `TCDR_ADDR_RLD2_LOW: reg_rdata <= timer2_reload_low_r;
          `TCDR_ADDR_RLD2_HIGH: reg_rdata <= timer2_reload_high_r;
          `TCDR_ADDR_TMR2_LOW: reg_rdata <= timer2_count_low_r;
          `TCDR_ADDR_TMR2_HIGH: reg_rdata <= timer2_count_high_r;
          default: reg_rdata <= `TCDR_RST_BYTE;
        endcase
      end
    end
  end

endmodule // tcdr_top
`default_nettype wire

/* verification/tcdr_top_props.sv */
/*
  Port checker for tcdr_top: register read port and flag set and clear causes.
  Assumes one clock, synchronous active-high reset, and the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdr_top_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer2_trigger_pin,
  input wire logic ack_timer0,
  input wire logic ack_timer1,
  input wire logic ack_ext_irq0,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic ext_irq0_flag,
  input wire logic ext_irq1_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_ext_flag
);
  wire w88 = reg_write && reg_addr == 8'h88;
  wire wc8 = reg_write && reg_addr == 8'hC8;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd_unmapped;
    reg_read && reg_addr == 8'h80;
  endsequence
  // A software write is always an allowed cause, so these only catch stray changes.
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (s_rd_unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_tf0_clear: assert property ($fell(timer0_overflow_flag) |-> $past(ack_timer0 || w88))
    else $error("timer 0 flag cleared without cause");
  a_tf1_clear: assert property ($fell(timer1_overflow_flag) |-> $past(ack_timer1 || w88))
    else $error("timer 1 flag cleared without cause");
  a_ie0_set: assert property ($rose(ext_irq0_flag) |-> $past(!ext_irq0_pin || w88))
    else $error("interrupt 0 flag set with pin high");
  a_ie1_set: assert property ($rose(ext_irq1_flag) |-> $past(!ext_irq1_pin || w88))
    else $error("interrupt 1 flag set with pin high");
  a_ie0_clear: assert property ($fell(ext_irq0_flag)
    |-> $past(ack_ext_irq0 || w88 || ext_irq0_pin))
    else $error("interrupt 0 flag cleared without cause");
  a_tf2_sw_clear: assert property ($fell(timer2_overflow_flag) |-> $past(wc8))
    else $error("timer 2 flag cleared by hardware");
  a_timer2_ext_flag_sw_clear: assert property ($fell(timer2_ext_flag) |-> $past(wc8))
    else $error("timer 2 external flag cleared by hardware");
  a_timer2_ext_flag_cause: assert property ($rose(timer2_ext_flag) |-> $past(wc8)
    || ($past(!timer2_trigger_pin) && $past(timer2_trigger_pin, 2)))
    else $error("timer 2 external flag set without trigger fall");
endmodule // tcdr_top_props
bind tcdr_top tcdr_top_props tcdr_top_props_i (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
  .timer2_trigger_pin(timer2_trigger_pin), .ack_timer0(ack_timer0), .ack_timer1(ack_timer1),
  .ack_ext_irq0(ack_ext_irq0), .timer0_overflow_flag(timer0_overflow_flag),
  .timer1_overflow_flag(timer1_overflow_flag), .ext_irq0_flag(ext_irq0_flag),
  .ext_irq1_flag(ext_irq1_flag), .timer2_overflow_flag(timer2_overflow_flag),
  .timer2_ext_flag(timer2_ext_flag));
`default_nettype wire

/* verification/tcdr_core_model.sv */
/*
  Core-side vectoring model: pulses one acknowledge per pending flag.
  Assumes flags are registered levels; delay sets how slowly the core answers.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdr_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic [1:0] delay,
  input wire logic [3:0] flags,
  output logic [3:0] acks
);
  logic [1:0] wait_r;
  // All pending flags are acknowledged at once, and never while an acknowledge is still in flight.
  always @(posedge clock) begin
    acks <= 4'h0;
    if (reset || !enable) begin
      wait_r <= 2'h0;
    end else if (flags != 4'h0 && acks == 4'h0) begin
      if (wait_r == delay) begin
        acks <= flags;
        wait_r <= 2'h0;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // tcdr_core_model
`default_nettype wire

/* verification/tcdr_top_bench.sv */
/*
  Self-checking bench for tcdr_top with the core acknowledge model.
  Assumes the checker is bound to the design from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdr_top_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic ext_irq0_pin = 1'b1;
  logic [2:0] pin_r = 3'h7;
  logic ack_en = 1'b0;
  logic [7:0] d;
  logic [7:0] e;
  wire [7:0] reg_rdata;
  wire [5:0] fl;
  wire [3:0] ack;
  wire rx_t;
  wire tx_t;
  integer n_fail = 0, comparisons = 0, cycles = 0, n_rx = 0, n_tx = 0, rx0, tx0;
  localparam logic [7:0] data_map [0:7] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D,
    8'hCC, 8'hCD, 8'hCA, 8'hCB};
  tcdr_top tcdr_top_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(pin_r[2]), .timer0_count_pin(1'b1),
    .timer1_count_pin(1'b1), .timer2_count_pin(pin_r[0]), .timer2_trigger_pin(pin_r[1]),
    .ack_timer0(ack[0]), .ack_timer1(ack[1]), .ack_ext_irq0(ack[2]), .ack_ext_irq1(ack[3]),
    .timer0_overflow_flag(fl[0]), .timer1_overflow_flag(fl[1]), .ext_irq0_flag(fl[2]),
    .ext_irq1_flag(fl[3]), .timer2_overflow_flag(fl[4]), .timer2_ext_flag(fl[5]),
    .rx_baud_tick(rx_t), .tx_baud_tick(tx_t));
  tcdr_core_model tcdr_core_model_i (.clock(clock), .reset(reset), .enable(ack_en),
    .delay(2'h2), .flags(fl[3:0]), .acks(ack));
  initial begin
    forever #10 clock = ~clock;
  end
  // Baud ticks are single-cycle pulses, so they are counted rather than sampled.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rx_t === 1'b1) n_rx <= n_rx + 1;
    if (tx_t === 1'b1) n_tx <= n_tx + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task end_of_test;
    $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task pulse(input integer k);
    @(posedge clock);
    pin_r[k] <= 1'b0;
    @(posedge clock);
    pin_r[k] <= 1'b1;
    cyc(1);
  endtask
  task t_reset;
    integer i;
    rdc(8'h88, 8'h00);
    rdc(8'hC8, 8'h00);
    for (i = 0; i < 8; i++) rdc(data_map[i], 8'h00);
    rdc(8'h80, 8'h00);
  endtask
  task t_rw;
    integer i;
    for (i = 0; i < 8; i++) wr(data_map[i], 8'hA0 + 8'(i));
    for (i = 0; i < 8; i++) rdc(data_map[i], 8'hA0 + 8'(i));
  endtask
  task t_timer0;
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFE);
    wr(8'h89, 8'h09);
    ext_irq0_pin <= 1'b0;
    wr(8'h88, 8'h10);
    cyc(4);
    rdc(8'h8A, 8'hFE);
    @(posedge clock);
    ext_irq0_pin <= 1'b1;
    cyc(1);
    chk(fl[0], 8'h00);
    cyc(3);
    chk(fl[0], 8'h01);
    cyc(5);
    chk(fl[0], 8'h01);
    ack_en <= 1'b1;
    cyc(8);
    chk(fl[0], 8'h00);
    ack_en <= 1'b0;
    wr(8'h88, 8'h00);
    rd(8'h8A, e);
    rdc(8'h8A, e);
  endtask
  task t_timer1;
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hFE);
    wr(8'h8B, 8'hFE);
    rx0 = n_rx;
    tx0 = n_tx;
    wr(8'h88, 8'h40);
    cyc(6);
    chk(fl[1], 8'h01);
    chk(8'(n_rx > rx0), 8'h01);
    chk(8'(n_tx > tx0), 8'h01);
    wr(8'h88, 8'h00);
    rdc(8'h8D, 8'hFE);
    rd(8'h8B, e);
    rdc(8'h8B, e);
  endtask
  task t_irq;
    @(posedge clock);
    ext_irq0_pin <= 1'b0;
    cyc(3);
    chk(fl[2], 8'h01);
    @(posedge clock);
    ext_irq0_pin <= 1'b1;
    cyc(3);
    chk(fl[2], 8'h00);
    rd(8'h8A, e);
    wr(8'h88, 8'h05);
    pulse(2);
    cyc(3);
    chk(fl[3], 8'h01);
    rdc(8'h88, 8'h0D);
    rdc(8'h8A, e);
    ack_en <= 1'b1;
    cyc(8);
    chk(fl[3], 8'h00);
    ack_en <= 1'b0;
    wr(8'h88, 8'h00);
  endtask
  task t_timer2;
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h0F);
    repeat (3) pulse(0);
    pulse(1);
    cyc(2);
    chk(fl[5], 8'h01);
    rdc(8'hCA, 8'h03);
    rdc(8'hCB, 8'h00);
    rdc(8'hCC, 8'h03);
    wr(8'hC8, 8'h06);
    pulse(1);
    cyc(2);
    chk(fl[5], 8'h00);
    wr(8'hCA, 8'h40);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    pulse(0);
    cyc(2);
    chk(fl[4], 8'h01);
    rdc(8'hCC, 8'h40);
    rdc(8'hCD, 8'h12);
    wr(8'hC8, 8'h0E);
    wr(8'hCC, 8'h00);
    pulse(1);
    cyc(2);
    chk(fl[5], 8'h01);
    rdc(8'hCC, 8'h40);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    rx0 = n_rx;
    tx0 = n_tx;
    wr(8'hC8, 8'h37);
    pulse(0);
    cyc(2);
    chk(fl[4], 8'h00);
    chk(8'(n_rx - rx0), 8'h01);
    chk(8'(n_tx - tx0), 8'h01);
    rdc(8'hCC, 8'h40);
    wr(8'hC8, 8'h02);
    pulse(0);
    rdc(8'hCC, 8'h40);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_rw;
    t_timer0;
    t_timer1;
    t_irq;
    t_timer2;
    end_of_test;
  end
endmodule // tcdr_top_bench
`default_nettype wire
